// file: design/asmsi_pkg.sv
// package: register indices, field positions, reset values and codes of the converter sfr front end
package asmsi_pkg;

  // register indices; byte address on apb is four times the index
  localparam logic [7:0] IDX_MODE     = 8'hD1;
  localparam logic [7:0] IDX_SF       = 8'hD4;
  localparam logic [7:0] IDX_STATUS   = 8'hD8;
  localparam logic [7:0] IDX_RES0_MID = 8'hDA;
  localparam logic [7:0] IDX_RES0_HI  = 8'hDB;
  localparam logic [7:0] IDX_RES1_LO  = 8'hDC;
  localparam logic [7:0] IDX_RES1_HI  = 8'hDD;
  localparam logic [7:0] IDX_OFF0_MID = 8'hE2;
  localparam logic [7:0] IDX_OFF0_HI  = 8'hE3;
  localparam logic [7:0] IDX_OFF1_LO  = 8'hE4;
  localparam logic [7:0] IDX_OFF1_HI  = 8'hE5;
  localparam logic [7:0] IDX_GAIN0_MID = 8'hEA;
  localparam logic [7:0] IDX_GAIN0_HI  = 8'hEB;
  localparam logic [7:0] IDX_GAIN1_LO  = 8'hEC;
  localparam logic [7:0] IDX_GAIN1_HI  = 8'hED;

  localparam int APB_AW = 12;

  // status bit positions
  localparam int ST_PRIM_RDY = 7;
  localparam int ST_AUX_RDY  = 6;
  localparam int ST_CAL      = 5;
  localparam int ST_NOREF    = 4;
  localparam int ST_PRIM_ERR = 3;
  localparam int ST_AUX_ERR  = 2;

  // mode register fields
  localparam int MD_PRIM_EN = 5;
  localparam int MD_AUX_EN  = 4;
  localparam logic [7:0] MODE_WMASK = 8'h37;

  // reset values, and the all-ones result word forced when the reference is missing while the external reference is selected
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [7:0]  SF_RST     = 8'h45;
  localparam logic [15:0] RES_RST    = 16'h0000;
  localparam logic [15:0] ALL_ONES   = 16'hFFFF;

  typedef enum logic [2:0] {
    ASMSI_PWRDN  = 3'h0,
    ASMSI_IDLE   = 3'h1,
    ASMSI_SINGLE = 3'h2,
    ASMSI_CONT   = 3'h3
  } asmsi_mode_t;

  // per-converter state
  typedef struct packed {
    logic        rdy;
    logic        err;
    logic [15:0] res;
    logic [15:0] off;
    logic [15:0] gain;
  } asmsi_cvt_t;

endpackage

// file: design/asmsi_core.sv
// converter status/mode sfr front end with apb slave, flag logic and coefficient storage
////////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choice: the APB register port.
module asmsi_core #(
  parameter logic [15:0] FACT_OFF0  = 16'h8000,
  parameter logic [15:0] FACT_GAIN0 = 16'h5000,
  parameter logic [15:0] FACT_OFF1  = 16'h8000,
  parameter logic [15:0] FACT_GAIN1 = 16'h5000
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [asmsi_pkg::APB_AW-1:0]    paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // primary converter datapath
  input  wire logic                            prim_done,
  input  wire logic                            prim_was_cal,
  input  wire logic                            prim_cal_gain,
  input  wire logic [15:0]                     prim_data,
  input  wire logic                            prim_clamped,
  input  wire logic                            prim_cal_fail,
  // auxiliary converter datapath
  input  wire logic                            aux_done,
  input  wire logic                            aux_was_cal,
  input  wire logic                            aux_cal_gain,
  input  wire logic [15:0]                     aux_data,
  input  wire logic                            aux_clamped,
  input  wire logic                            aux_cal_fail,
  // reference monitor
  input  wire logic                            ref_low,
  input  wire logic                            ext_ref_sel,
  // converter control
  output logic                                 prim_enable,
  output logic                                 aux_enable,
  output logic      [2:0]                      conv_mode,
  output logic                                 prim_start,
  output logic                                 aux_start,
  output logic      [7:0]                      filter_decimation
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    asmsi_pkg::asmsi_cvt_t prim;
    asmsi_pkg::asmsi_cvt_t aux;
    logic                  cal_done;
    logic                  noref;
    logic [7:0]            mode;
    logic [7:0]            sf;
    logic [1:0]            pend;
    logic                  prim_start;
    logic                  aux_start;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } asmsi_state_t;

  asmsi_state_t s_q;
  asmsi_state_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // mode codes that launch a conversion or calibration
  function automatic logic is_start(input logic [2:0] md);
    is_start = (md != asmsi_pkg::ASMSI_PWRDN) && (md != asmsi_pkg::ASMSI_IDLE);
  endfunction

  // a converter runs when enabled and its mode is neither power-down nor idle
  function automatic logic is_active(input logic en, input logic [2:0] md);
    is_active = en && is_start(md);
  endfunction

  // one converter's flags and stored words after clear and completion events
  function automatic asmsi_pkg::asmsi_cvt_t cvt_next(
    input asmsi_pkg::asmsi_cvt_t cur,
    input logic                  clr_all,
    input logic                  clr_rdy,
    input logic                  done,
    input logic                  was_cal,
    input logic                  cal_gain,
    input logic [15:0]           data,
    input logic                  clamped,
    input logic                  cal_fail,
    input logic                  force_ones
  );
    asmsi_pkg::asmsi_cvt_t n;
    n = cur;
    if (clr_all) begin
      n.rdy = 1'b0;
      n.err = 1'b0;
    end
    if (clr_rdy) begin
      n.rdy = 1'b0;
    end
    // a completion in the clearing cycle still lands: set wins over clear
    if (done && (!cur.rdy || clr_all || clr_rdy)) begin
      n.rdy = 1'b1;
      if (was_cal) begin
        if (cal_fail) begin
          n.err = 1'b1;
        end else if (cal_gain) begin
          n.gain = data;
        end else begin
          n.off = data;
        end
      end else if (force_ones) begin
        n.res = asmsi_pkg::ALL_ONES;
      end else begin
        n.res = data;
        if (clamped) begin
          n.err = 1'b1;
        end
      end
    end
    cvt_next = n;
  endfunction

  // read value of a register; top bit flags a mapped index
  function automatic logic [8:0] rd_byte(input asmsi_state_t st, input logic [7:0] idx);
    logic [7:0] stat;
    stat = asmsi_pkg::STATUS_RST;
    stat[asmsi_pkg::ST_PRIM_RDY] = st.prim.rdy;
    stat[asmsi_pkg::ST_AUX_RDY]  = st.aux.rdy;
    stat[asmsi_pkg::ST_CAL]      = st.cal_done;
    stat[asmsi_pkg::ST_NOREF]    = st.noref;
    stat[asmsi_pkg::ST_PRIM_ERR] = st.prim.err;
    stat[asmsi_pkg::ST_AUX_ERR]  = st.aux.err;
    unique case (idx)
      asmsi_pkg::IDX_STATUS:    rd_byte = {1'b1, stat};
      asmsi_pkg::IDX_MODE:      rd_byte = {1'b1, st.mode};
      asmsi_pkg::IDX_SF:        rd_byte = {1'b1, st.sf};
      asmsi_pkg::IDX_RES0_MID:  rd_byte = {1'b1, st.prim.res[7:0]};
      asmsi_pkg::IDX_RES0_HI:   rd_byte = {1'b1, st.prim.res[15:8]};
      asmsi_pkg::IDX_RES1_LO:   rd_byte = {1'b1, st.aux.res[7:0]};
      asmsi_pkg::IDX_RES1_HI:   rd_byte = {1'b1, st.aux.res[15:8]};
      asmsi_pkg::IDX_OFF0_MID:  rd_byte = {1'b1, st.prim.off[7:0]};
      asmsi_pkg::IDX_OFF0_HI:   rd_byte = {1'b1, st.prim.off[15:8]};
      asmsi_pkg::IDX_OFF1_LO:   rd_byte = {1'b1, st.aux.off[7:0]};
      asmsi_pkg::IDX_OFF1_HI:   rd_byte = {1'b1, st.aux.off[15:8]};
      asmsi_pkg::IDX_GAIN0_MID: rd_byte = {1'b1, st.prim.gain[7:0]};
      asmsi_pkg::IDX_GAIN0_HI:  rd_byte = {1'b1, st.prim.gain[15:8]};
      asmsi_pkg::IDX_GAIN1_LO:  rd_byte = {1'b1, st.aux.gain[7:0]};
      asmsi_pkg::IDX_GAIN1_HI:  rd_byte = {1'b1, st.aux.gain[15:8]};
      default:                  rd_byte = 9'h000;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] idx;
  logic       aligned;
  logic       setup;
  logic       wr_commit;
  logic [8:0] rd_now;
  logic [7:0] wbyte;
  logic       wr_mode;
  logic       wr_stat;
  logic       wr_sf;
  logic       launch;
  logic       prim_clr;
  logic       aux_clr;
  logic       prim_act;
  logic       aux_act;
  logic       force_ones;
  logic [1:0] pend_n;
  logic       prim_wclr;
  logic       aux_wclr;
  logic       prim_land;
  logic       aux_land;

  assign idx       = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'h0) && (paddr[asmsi_pkg::APB_AW-1:10] == 2'h0);
  assign setup     = psel && !penable;
  assign wr_commit = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
  assign rd_now    = rd_byte(s_q, idx);
  assign wbyte     = pwdata[7:0];
  assign wr_mode   = wr_commit && (idx == asmsi_pkg::IDX_MODE);
  assign wr_stat   = wr_commit && (idx == asmsi_pkg::IDX_STATUS);
  assign wr_sf     = wr_commit && (idx == asmsi_pkg::IDX_SF);
  assign launch    = wr_mode && is_start(wbyte[2:0]);
  assign prim_clr  = launch && wbyte[asmsi_pkg::MD_PRIM_EN];
  assign aux_clr   = launch && wbyte[asmsi_pkg::MD_AUX_EN];
  assign prim_act  = is_active(s_q.mode[asmsi_pkg::MD_PRIM_EN], s_q.mode[2:0]);
  assign aux_act   = is_active(s_q.mode[asmsi_pkg::MD_AUX_EN], s_q.mode[2:0]);
  assign force_ones = s_q.noref && ext_ref_sel;
  assign prim_wclr  = wr_stat && !wbyte[asmsi_pkg::ST_PRIM_RDY];
  assign aux_wclr   = wr_stat && !wbyte[asmsi_pkg::ST_AUX_RDY];
  // a completion lands when ready is clear or is being cleared in the same cycle
  assign prim_land  = prim_done && prim_act && (!s_q.prim.rdy || prim_clr || prim_wclr);
  assign aux_land   = aux_done && aux_act && (!s_q.aux.rdy || aux_clr || aux_wclr);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.prim_start = 1'b0;
    s_d.aux_start  = 1'b0;
    pend_n         = s_q.pend;

    // apb: registered answer in the first access cycle, no further wait
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.pslverr = !(aligned && rd_now[8]);
      s_d.prdata  = (aligned && !pwrite) ? {24'h000000, rd_now[7:0]} : 32'h00000000;
    end

    // converter flags and stored words; idle or powered-down converters drop completions
    s_d.prim = cvt_next(s_q.prim, prim_clr, prim_wclr,
                        prim_done && prim_act, prim_was_cal, prim_cal_gain,
                        prim_data, prim_clamped, prim_cal_fail, force_ones);
    s_d.aux  = cvt_next(s_q.aux, aux_clr, aux_wclr,
                        aux_done && aux_act, aux_was_cal, aux_cal_gain,
                        aux_data, aux_clamped, aux_cal_fail, force_ones);

    // calibration-done: cleared by any starting write, set wins
    if (launch) begin
      s_d.cal_done = 1'b0;
    end
    if ((prim_land && prim_was_cal) || (aux_land && aux_was_cal)) begin
      s_d.cal_done = 1'b1;
    end

    // reference monitor only counts while a converter runs
    s_d.noref = ref_low && (prim_act || aux_act);

    // filter decimation
    if (wr_sf) begin
      s_d.sf = wbyte;
    end

    // completion of one-shot modes drops the pending mark of that converter
    if (prim_done && prim_act) begin
      pend_n[1] = 1'b0;
    end
    if (aux_done && aux_act) begin
      pend_n[0] = 1'b0;
    end
    if ((s_q.pend != 2'h0) && (pend_n == 2'h0)) begin
      s_d.mode[2:0] = asmsi_pkg::ASMSI_PWRDN;
    end
    s_d.pend = pend_n;

    // whole-byte mode write; reserved bits stay zero
    if (wr_mode) begin
      s_d.mode       = wbyte & asmsi_pkg::MODE_WMASK;
      s_d.prim_start = prim_clr;
      s_d.aux_start  = aux_clr;
      s_d.pend       = 2'h0;
      if (launch && (wbyte[2:0] != asmsi_pkg::ASMSI_CONT)) begin
        s_d.pend = {wbyte[asmsi_pkg::MD_PRIM_EN], wbyte[asmsi_pkg::MD_AUX_EN]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.prim.rdy   <= 1'b0;
      s_q.prim.err   <= 1'b0;
      s_q.prim.res   <= asmsi_pkg::RES_RST;
      s_q.prim.off   <= FACT_OFF0;
      s_q.prim.gain  <= FACT_GAIN0;
      s_q.aux.rdy    <= 1'b0;
      s_q.aux.err    <= 1'b0;
      s_q.aux.res    <= asmsi_pkg::RES_RST;
      s_q.aux.off    <= FACT_OFF1;
      s_q.aux.gain   <= FACT_GAIN1;
      s_q.cal_done   <= 1'b0;
      s_q.noref      <= 1'b0;
      s_q.mode       <= asmsi_pkg::MODE_RST;
      s_q.sf         <= asmsi_pkg::SF_RST;
      s_q.pend       <= 2'h0;
      s_q.prim_start <= 1'b0;
      s_q.aux_start  <= 1'b0;
      s_q.pready     <= 1'b0;
      s_q.pslverr    <= 1'b0;
      s_q.prdata     <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = s_q.pslverr;
  assign prim_enable       = s_q.mode[asmsi_pkg::MD_PRIM_EN];
  assign aux_enable        = s_q.mode[asmsi_pkg::MD_AUX_EN];
  assign conv_mode         = s_q.mode[2:0];
  assign prim_start        = s_q.prim_start;
  assign aux_start         = s_q.aux_start;
  assign filter_decimation = s_q.sf;

endmodule

// file: test/asmsi_properties.sv
// checker: concurrent properties on the ports of the converter sfr front end
module asmsi_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // converter side
  input wire logic        prim_done,
  input wire logic        aux_done,
  input wire logic        prim_enable,
  input wire logic        aux_enable,
  input wire logic [2:0]  conv_mode,
  input wire logic        prim_start,
  input wire logic        aux_start,
  input wire logic [7:0]  filter_decimation
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  logic mwr;
  logic strt;
  assign acc  = psel && penable && pready;
  assign mwr  = acc && pwrite && paddr == 12'h344 && !prim_done && !aux_done;
  assign strt = mwr && pwdata[2:1] != 2'h0;
  ////////////////////////////////////////
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one cycle answer");
  mode_reset_a: assert property ($fell(rst) |-> conv_mode == 3'h0 && !prim_enable && !aux_enable)
    else $error("mode not cleared by reset");
  mode_write_a: assert property (mwr |=> conv_mode == $past(pwdata[2:0]) && prim_enable == $past(pwdata[5]))
    else $error("mode write not applied");
  prim_start_a: assert property (strt && pwdata[5] |=> prim_start ##1 !prim_start)
    else $error("primary start pulse wrong");
  aux_start_a: assert property (strt && pwdata[4] |=> aux_start ##1 !aux_start)
    else $error("auxiliary start pulse wrong");
  single_end_a: assert property (conv_mode == 3'h2 && prim_enable && !aux_enable && prim_done
    |-> ##[1:2] conv_mode == 3'h0)
    else $error("single conversion did not return to power-down");
  status_rsvd_a: assert property (acc && !pwrite && paddr == 12'h360 |-> prdata[1:0] == 2'h0)
    else $error("reserved status bits not zero");
  mode_read_a: assert property (acc && !pwrite && paddr == 12'h344
    |-> prdata[7:0] == {2'h0, $past(prim_enable), $past(aux_enable), 1'h0, $past(conv_mode)})
    else $error("mode readback differs from outputs");
  sf_read_a: assert property (acc && !pwrite && paddr == 12'h350 |-> prdata[7:0] == filter_decimation)
    else $error("filter register readback differs");
  cover property (strt);
  cover property (prim_done && conv_mode == 3'h2);
  cover property (acc && !pwrite && paddr == 12'h360);
endmodule

bind asmsi_core asmsi_props u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .prim_done, .aux_done, .prim_enable, .aux_enable, .conv_mode, .prim_start, .aux_start, .filter_decimation);

// file: test/test_adc_status_mode_sfr_interface.sv
// testbench: apb register sequences against the converter sfr front end
module test_adc_status_mode_sfr_interface;
  timeunit 1ns;
  timeprecision 1ps;
  // factory coefficients, arbitrary distinct values
  localparam logic [15:0] O0 = 16'h1357;
  localparam logic [15:0] G0 = 16'h2468;
  localparam logic [15:0] O1 = 16'h9ABC;
  localparam logic [15:0] G1 = 16'hDEF0;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  done = 2'h0;
  logic [1:0]  was_cal = 2'h0;
  logic [1:0]  cal_gain = 2'h0;
  logic [1:0]  clamped = 2'h0;
  logic [1:0]  cal_fail = 2'h0;
  logic [15:0] data [2] = '{16'h0, 16'h0};
  logic        ref_low = 1'h0;
  logic        ext_ref_sel = 1'h0;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #2.5 clk = ~clk;

  asmsi_core #(.FACT_OFF0(O0), .FACT_GAIN0(G0), .FACT_OFF1(O1), .FACT_GAIN1(G1)) dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .prim_done(done[0]), .prim_was_cal(was_cal[0]), .prim_cal_gain(cal_gain[0]), .prim_data(data[0]),
    .prim_clamped(clamped[0]), .prim_cal_fail(cal_fail[0]),
    .aux_done(done[1]), .aux_was_cal(was_cal[1]), .aux_cal_gain(cal_gain[1]), .aux_data(data[1]),
    .aux_clamped(clamped[1]), .aux_cal_fail(cal_fail[1]),
    .ref_low, .ext_ref_sel, .prim_enable(), .aux_enable(), .conv_mode(), .prim_start(), .aux_start(),
    .filter_decimation());
  ////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'h1, i, d, r, e);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] x, input logic ex = 1'h0);
    logic [7:0] r;
    logic       e;
    apb(1'h0, i, 8'h00, r, e);
    chk(r, x);
    chk({7'h0, e}, {7'h0, ex});
  endtask

  // f holds calibration, gain, clamp and failure qualifiers
  task automatic pulse(input int a, input logic [15:0] d, input logic [3:0] f);
    {was_cal[a], cal_gain[a], clamped[a], cal_fail[a]} <= f;
    data[a] <= d;
    done[a] <= 1'h1;
    @(posedge clk);
    done <= 2'h0;
    {was_cal, cal_gain, clamped, cal_fail} <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(8'hD8, 8'h00);
    rd(8'hD1, 8'h00);
    rd(8'hD4, 8'h45);
    rd(8'hE2, O0[7:0]);
    rd(8'hE3, O0[15:8]);
    rd(8'hE4, O1[7:0]);
    rd(8'hE5, O1[15:8]);
    rd(8'hEA, G0[7:0]);
    rd(8'hEB, G0[15:8]);
    rd(8'hEC, G1[7:0]);
    rd(8'hED, G1[15:8]);
    rd(8'h10, 8'h00, 1'h1);
    wr(8'hD4, 8'h5A);
    rd(8'hD4, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD1, 8'hF8 | i[7:0]);
      rd(8'hD1, 8'h30 | i[7:0]);
    end
    wr(8'hD1, 8'h22);
    pulse(0, 16'h1234, 4'h0);
    rd(8'hD8, 8'h80);
    rd(8'hDA, 8'h34);
    rd(8'hDB, 8'h12);
    rd(8'hD1, 8'h20);
    wr(8'hDB, 8'hAA);
    rd(8'hDB, 8'h12);
    wr(8'hD1, 8'h23);
    rd(8'hD8, 8'h00);
    pulse(0, 16'h1111, 4'h0);
    pulse(0, 16'h2222, 4'h2);
    rd(8'hDB, 8'h11);
    rd(8'hD8, 8'h80);
    wr(8'hD8, 8'h7F);
    rd(8'hD8, 8'h00);
    pulse(0, 16'h5678, 4'h2);
    rd(8'hD8, 8'h88);
    rd(8'hDA, 8'h78);
    wr(8'hD1, 8'h23);
    rd(8'hD8, 8'h00);
    ref_low <= 1'h1;
    ext_ref_sel <= 1'h1;
    wr(8'hD1, 8'h33);
    pulse(1, 16'h0F0F, 4'h0);
    rd(8'hD8, 8'h50);
    rd(8'hDC, 8'hFF);
    rd(8'hDD, 8'hFF);
    ref_low <= 1'h0;
    wr(8'hD1, 8'h14);
    rd(8'hD8, 8'h00);
    pulse(1, 16'h4321, 4'hC);
    rd(8'hD8, 8'h60);
    rd(8'hEC, 8'h21);
    rd(8'hED, 8'h43);
    wr(8'hD8, 8'hBF);
    rd(8'hD8, 8'h20);
    wr(8'hD1, 8'h14);
    rd(8'hD8, 8'h00);
    pulse(1, 16'h0000, 4'h9);
    rd(8'hD8, 8'h64);
    rd(8'hE4, O1[7:0]);
    give_verdict;
  end
endmodule
